/* File: hdl/tcb_params.svh */
`ifndef TCB_PARAMS_SVH
`define TCB_PARAMS_SVH

// ==========================================================================
// timing
`define TCB_CLK_HZ          250000000
`define TCB_UPDATE_HZ       16000

// ==========================================================================
// geometry
`define TCB_WORD_W          16
`define TCB_ADDR_W          8
`define TCB_GAIN_W          12
`define TCB_GAIN_FRAC       10
`define TCB_NUM_COEFFS      27

// ==========================================================================
// indirect addresses
`define TCB_ADDR_TONE1_FREQ      8'h00
`define TCB_ADDR_TONE1_AMP       8'h01
`define TCB_ADDR_TONE1_PHASE     8'h02
`define TCB_ADDR_TONE2_FREQ      8'h03
`define TCB_ADDR_TONE2_AMP       8'h04
`define TCB_ADDR_TONE2_PHASE     8'h05
`define TCB_ADDR_RING_DC_OFFSET  8'h06
`define TCB_ADDR_RING_FREQ       8'h07
`define TCB_ADDR_RING_AMP        8'h08
`define TCB_ADDR_RING_PHASE      8'h09
`define TCB_ADDR_RX_GAIN         8'h0D
`define TCB_ADDR_TX_GAIN         8'h0E
`define TCB_ADDR_LC_UPPER        8'h0F
`define TCB_ADDR_RT_THRESH       8'h10
`define TCB_ADDR_CM_LOW          8'h11
`define TCB_ADDR_CM_HIGH         8'h12
`define TCB_ADDR_PWR_PAIR1       8'h13
`define TCB_ADDR_PWR_PAIR2       8'h14
`define TCB_ADDR_PWR_PAIR3       8'h15
`define TCB_ADDR_LC_FILTER       8'h16
`define TCB_ADDR_RT_FILTER       8'h17
`define TCB_ADDR_THERM_PAIR1     8'h18
`define TCB_ADDR_THERM_PAIR2     8'h19
`define TCB_ADDR_THERM_PAIR3     8'h1A
`define TCB_ADDR_RING_CM_BIAS    8'h1B
`define TCB_ADDR_CONV_OVERHEAD   8'h40
`define TCB_ADDR_LC_LOWER        8'h42

// ==========================================================================
// reset values of the direct port registers
`define TCB_DATA_RESET      16'h0000
`define TCB_ADDR_RESET      8'h00

`endif

/* File: hdl/tcb_pkg.sv */
`include "tcb_params.svh"

package tcb_pkg;

    typedef logic [`TCB_WORD_W-1:0] tcb_word_type;
    typedef logic [`TCB_ADDR_W-1:0] tcb_addr_type;

    typedef enum logic [1:0] {
        XFER_IDLE,
        XFER_WRITE,
        XFER_READ
    } tcb_xfer_state_type;

    // maps an indirect address onto a storage slot; bit 5 flags a mapped address
    function automatic logic [5:0] coeff_slot(input tcb_addr_type addr);
        logic [5:0] slot;
        slot = 6'h00;
        if (addr <= `TCB_ADDR_RING_PHASE) begin
            slot = {1'b1, addr[4:0]};
        end else if (addr >= `TCB_ADDR_RX_GAIN && addr <= `TCB_ADDR_RING_CM_BIAS) begin
            slot = {1'b1, 5'(addr - 8'h03)};
        end else if (addr == `TCB_ADDR_CONV_OVERHEAD) begin
            slot = {1'b1, 5'h19};
        end else if (addr == `TCB_ADDR_LC_LOWER) begin
            slot = {1'b1, 5'h1A};
        end
        return slot;
    endfunction

endpackage

/* File: hdl/tcb_coeff_store.sv */
`timescale 1ns/1ns
`include "tcb_params.svh"

module tcb_coeff_store (
    // clock
    input  wire logic                                clk,
    // write side
    input  wire logic                                wrEn,
    input  wire tcb_pkg::tcb_addr_type               wrAddr,
    input  wire tcb_pkg::tcb_word_type               wrData,
    // read side
    input  wire tcb_pkg::tcb_addr_type               rdAddr,
    output tcb_pkg::tcb_word_type                    rdData,
    // all words, slot order
    output logic [`TCB_NUM_COEFFS*`TCB_WORD_W-1:0]   coeffWords
);

    // ======================================================================
    // storage, left without reset: contents are undefined until written
    tcb_pkg::tcb_word_type memReg  [`TCB_NUM_COEFFS];
    tcb_pkg::tcb_word_type memNext [`TCB_NUM_COEFFS];
    logic [5:0]            wrSlot;
    logic [5:0]            rdSlot;

    assign wrSlot = tcb_pkg::coeff_slot(wrAddr);
    assign rdSlot = tcb_pkg::coeff_slot(rdAddr);

    // every bit is kept, unused positions stay readable and writable
    always_comb begin
        for (int i = 0; i < `TCB_NUM_COEFFS; i++) begin
            memNext[i] = memReg[i];
        end
        if (wrEn && wrSlot[5]) begin
            memNext[wrSlot[4:0]] = wrData;
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < `TCB_NUM_COEFFS; i++) begin
            memReg[i] <= memNext[i];
        end
    end

    // unmapped addresses read as zero
    assign rdData = rdSlot[5] ? memReg[rdSlot[4:0]] : `TCB_WORD_W'(0);

    genvar g;
    generate
        for (g = 0; g < `TCB_NUM_COEFFS; g++) begin : gWords
            assign coeffWords[g*`TCB_WORD_W +: `TCB_WORD_W] = memReg[g];
        end
    endgenerate

endmodule

/* File: hdl/tcb_gain_scaler.sv */
`timescale 1ns/1ns
`include "tcb_params.svh"

module tcb_gain_scaler (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // sample in
    input  wire logic signed [`TCB_WORD_W-1:0] sampleIn,
    input  wire logic                          sampleInValid,
    input  wire logic signed [`TCB_GAIN_W-1:0] gain,
    // sample out
    output logic signed [`TCB_WORD_W-1:0]      sampleOut,
    output logic                               sampleOutValid
);

    localparam int PW = `TCB_WORD_W + `TCB_GAIN_W;

    logic signed [PW-1:0]            product;
    logic signed [PW-1:0]            shifted;
    logic signed [`TCB_WORD_W-1:0]   sampleReg;
    logic signed [`TCB_WORD_W-1:0]   sampleNext;
    logic                            validReg;
    logic                            validNext;

    // ======================================================================
    // multiply, drop the fraction, saturate to the sample width
    assign product = PW'(sampleIn) * PW'(gain);
    assign shifted = product >>> `TCB_GAIN_FRAC;

    always_comb begin
        sampleNext = sampleReg;
        validNext  = sampleInValid;
        if (sampleInValid) begin
            if (shifted > PW'(16'sh7FFF)) begin
                sampleNext = 16'sh7FFF;
            end else if (shifted < PW'(-17'sh08000)) begin
                sampleNext = -16'sh8000;
            end else begin
                sampleNext = shifted[`TCB_WORD_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sampleReg <= 16'h0000;
            validReg  <= 1'b0;
        end else begin
            sampleReg <= sampleNext;
            validReg  <= validNext;
        end
    end

    assign sampleOut      = sampleReg;
    assign sampleOutValid = validReg;

endmodule

/* File: hdl/tcb_coeff_bank.sv */
`timescale 1ns/1ns
`include "tcb_params.svh"

module tcb_coeff_bank #(
    parameter int UPDATE_CYCLES = `TCB_CLK_HZ / `TCB_UPDATE_HZ
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // host write strobes
    input  wire logic                          dataPortWrite,
    input  wire tcb_pkg::tcb_word_type         dataPortIn,
    input  wire logic                          addrPortWrite,
    input  wire tcb_pkg::tcb_addr_type         addrPortIn,
    // host read view
    output tcb_pkg::tcb_word_type              indirectDataPort,
    output tcb_pkg::tcb_addr_type              indirectAddressPort,
    output logic                               indirectPendingFlag,
    output logic                               transferDone,
    // tone generators
    output logic signed [`TCB_WORD_W-1:0]      tone1FrequencyCoeff,
    output logic signed [`TCB_WORD_W-1:0]      tone1Amplitude,
    output logic signed [`TCB_WORD_W-1:0]      tone1InitialPhase,
    output logic signed [`TCB_WORD_W-1:0]      tone2FrequencyCoeff,
    output logic signed [`TCB_WORD_W-1:0]      tone2Amplitude,
    output logic signed [`TCB_WORD_W-1:0]      tone2InitialPhase,
    // ringing generator
    output logic signed [`TCB_WORD_W-1:0]      ringDcOffset,
    output logic signed [`TCB_WORD_W-1:0]      ringFrequencyCoeff,
    output logic signed [`TCB_WORD_W-1:0]      ringAmplitude,
    output logic signed [`TCB_WORD_W-1:0]      ringInitialPhase,
    // line control words
    output logic signed [`TCB_WORD_W-1:0]      loopClosureUpperThreshold,
    output logic signed [`TCB_WORD_W-1:0]      ringTripThreshold,
    output logic signed [`TCB_WORD_W-1:0]      commonModeLowThreshold,
    output logic signed [`TCB_WORD_W-1:0]      commonModeHighThreshold,
    output logic signed [`TCB_WORD_W-1:0]      powerAlarmThresholdPair1,
    output logic signed [`TCB_WORD_W-1:0]      powerAlarmThresholdPair2,
    output logic signed [`TCB_WORD_W-1:0]      powerAlarmThresholdPair3,
    // filters and thermal poles
    output logic signed [`TCB_WORD_W-1:0]      loopClosureFilterCoeff,
    output logic signed [`TCB_WORD_W-1:0]      ringTripFilterCoeff,
    output logic signed [`TCB_WORD_W-1:0]      thermalPolePair1,
    output logic signed [`TCB_WORD_W-1:0]      thermalPolePair2,
    output logic signed [`TCB_WORD_W-1:0]      thermalPolePair3,
    // bias, converter and lower loop closure threshold
    output logic signed [`TCB_WORD_W-1:0]      ringingCommonModeBias,
    output logic signed [`TCB_WORD_W-1:0]      converterOverheadVoltage,
    output logic signed [`TCB_WORD_W-1:0]      loopClosureLowerThreshold,
    // receive path samples
    input  wire logic signed [`TCB_WORD_W-1:0] rxSampleIn,
    input  wire logic                          rxSampleInValid,
    output logic signed [`TCB_WORD_W-1:0]      rxSampleOut,
    output logic                               rxSampleOutValid,
    // transmit path samples
    input  wire logic signed [`TCB_WORD_W-1:0] txSampleIn,
    input  wire logic                          txSampleInValid,
    output logic signed [`TCB_WORD_W-1:0]      txSampleOut,
    output logic                               txSampleOutValid
);

    localparam int TW = $clog2(UPDATE_CYCLES + 1);

    // ======================================================================
    // update rate timer
    logic [TW-1:0] tickCountReg;
    logic [TW-1:0] tickCountNext;
    logic          updateTick;

    // one tick per update period; every transfer waits for it
    assign updateTick = (tickCountReg == TW'(UPDATE_CYCLES - 1));

    always_comb begin
        if (updateTick) begin
            tickCountNext = TW'(0);
        end else begin
            tickCountNext = tickCountReg + TW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tickCountReg <= TW'(0);
        end else begin
            tickCountReg <= tickCountNext;
        end
    end

    // ======================================================================
    // indirect transfer control
    tcb_pkg::tcb_xfer_state_type stateReg;
    tcb_pkg::tcb_xfer_state_type stateNext;
    tcb_pkg::tcb_word_type       dataReg;
    tcb_pkg::tcb_word_type       dataNext;
    tcb_pkg::tcb_addr_type       addrReg;
    tcb_pkg::tcb_addr_type       addrNext;
    logic                        dataArmedReg;
    logic                        dataArmedNext;
    logic                        doneReg;
    logic                        doneNext;
    logic                        storeWrite;
    tcb_pkg::tcb_word_type       storeReadData;

    always_comb begin
        stateNext     = stateReg;
        dataNext      = dataReg;
        addrNext      = addrReg;
        dataArmedNext = dataArmedReg;
        doneNext      = 1'b0;
        storeWrite    = 1'b0;
        case (stateReg)
            tcb_pkg::XFER_IDLE: begin
                if (dataPortWrite) begin
                    dataNext      = dataPortIn;
                    dataArmedNext = 1'b1;
                end
                // an address write decides the direction of the transfer
                if (addrPortWrite) begin
                    addrNext      = addrPortIn;
                    dataArmedNext = 1'b0;
                    if (dataArmedReg || dataPortWrite) begin
                        stateNext = tcb_pkg::XFER_WRITE;
                    end else begin
                        stateNext = tcb_pkg::XFER_READ;
                    end
                end
            end
            tcb_pkg::XFER_WRITE: begin
                // host strobes are ignored until the tick services the transfer
                if (updateTick) begin
                    storeWrite = 1'b1;
                    doneNext   = 1'b1;
                    stateNext  = tcb_pkg::XFER_IDLE;
                end
            end
            tcb_pkg::XFER_READ: begin
                // unmapped addresses read back as zero and still complete
                if (updateTick) begin
                    dataNext  = storeReadData;
                    doneNext  = 1'b1;
                    stateNext = tcb_pkg::XFER_IDLE;
                end
            end
            default: begin
                stateNext = tcb_pkg::XFER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stateReg     <= tcb_pkg::XFER_IDLE;
            dataReg      <= `TCB_DATA_RESET;
            addrReg      <= `TCB_ADDR_RESET;
            dataArmedReg <= 1'b0;
            doneReg      <= 1'b0;
        end else begin
            stateReg     <= stateNext;
            dataReg      <= dataNext;
            addrReg      <= addrNext;
            dataArmedReg <= dataArmedNext;
            doneReg      <= doneNext;
        end
    end

    // pending follows the state, so it drops with the completion pulse
    assign indirectDataPort    = dataReg;
    assign indirectAddressPort = addrReg;
    assign indirectPendingFlag = (stateReg != tcb_pkg::XFER_IDLE);
    assign transferDone        = doneReg;

    // ======================================================================
    // coefficient storage, no reset on contents
    logic [`TCB_NUM_COEFFS*`TCB_WORD_W-1:0] coeffWords;

    tcb_coeff_store uStore (
        .clk        (clk),
        .wrEn       (storeWrite),
        .wrAddr     (addrReg),
        .wrData     (dataReg),
        .rdAddr     (addrReg),
        .rdData     (storeReadData),
        .coeffWords (coeffWords)
    );

    function automatic tcb_pkg::tcb_word_type word_at(input tcb_pkg::tcb_addr_type addr);
        logic [5:0] slot;
        slot = tcb_pkg::coeff_slot(addr);
        return coeffWords[slot[4:0]*`TCB_WORD_W +: `TCB_WORD_W];
    endfunction

    // ======================================================================
    // coefficient outputs, all two's complement
    // always_comb follows coeffWords inside word_at; a plain assign would not

    // tone generators
    always_comb begin
        tone1FrequencyCoeff       = word_at(`TCB_ADDR_TONE1_FREQ);
        tone1Amplitude            = word_at(`TCB_ADDR_TONE1_AMP);
        tone1InitialPhase         = word_at(`TCB_ADDR_TONE1_PHASE);
        tone2FrequencyCoeff       = word_at(`TCB_ADDR_TONE2_FREQ);
        tone2Amplitude            = word_at(`TCB_ADDR_TONE2_AMP);
        tone2InitialPhase         = word_at(`TCB_ADDR_TONE2_PHASE);
    end

    // ringing generator
    always_comb begin
        ringDcOffset              = word_at(`TCB_ADDR_RING_DC_OFFSET);
        ringFrequencyCoeff        = word_at(`TCB_ADDR_RING_FREQ);
        ringAmplitude             = word_at(`TCB_ADDR_RING_AMP);
        ringInitialPhase          = word_at(`TCB_ADDR_RING_PHASE);
    end

    // line control words, filters, thermal poles, bias, converter and lower threshold
    always_comb begin
        loopClosureUpperThreshold = word_at(`TCB_ADDR_LC_UPPER);
        ringTripThreshold         = word_at(`TCB_ADDR_RT_THRESH);
        commonModeLowThreshold    = word_at(`TCB_ADDR_CM_LOW);
        commonModeHighThreshold   = word_at(`TCB_ADDR_CM_HIGH);
        powerAlarmThresholdPair1  = word_at(`TCB_ADDR_PWR_PAIR1);
        powerAlarmThresholdPair2  = word_at(`TCB_ADDR_PWR_PAIR2);
        powerAlarmThresholdPair3  = word_at(`TCB_ADDR_PWR_PAIR3);
        loopClosureFilterCoeff    = word_at(`TCB_ADDR_LC_FILTER);
        ringTripFilterCoeff       = word_at(`TCB_ADDR_RT_FILTER);
        thermalPolePair1          = word_at(`TCB_ADDR_THERM_PAIR1);
        thermalPolePair2          = word_at(`TCB_ADDR_THERM_PAIR2);
        thermalPolePair3          = word_at(`TCB_ADDR_THERM_PAIR3);
        ringingCommonModeBias     = word_at(`TCB_ADDR_RING_CM_BIAS);
        converterOverheadVoltage  = word_at(`TCB_ADDR_CONV_OVERHEAD);
        loopClosureLowerThreshold = word_at(`TCB_ADDR_LC_LOWER);
    end

    // ======================================================================
    // digital gain on both audio paths
    logic signed [`TCB_GAIN_W-1:0] rxGain;
    logic signed [`TCB_GAIN_W-1:0] txGain;
    tcb_pkg::tcb_word_type         rxGainWord;
    tcb_pkg::tcb_word_type         txGainWord;

    always_comb begin
        rxGainWord = word_at(`TCB_ADDR_RX_GAIN);
        txGainWord = word_at(`TCB_ADDR_TX_GAIN);
    end
    assign rxGain     = rxGainWord[`TCB_GAIN_W-1:0];
    assign txGain     = txGainWord[`TCB_GAIN_W-1:0];

    tcb_gain_scaler uRxGain (
        .clk            (clk),
        .rst            (rst),
        .sampleIn       (rxSampleIn),
        .sampleInValid  (rxSampleInValid),
        .gain           (rxGain),
        .sampleOut      (rxSampleOut),
        .sampleOutValid (rxSampleOutValid)
    );

    tcb_gain_scaler uTxGain (
        .clk            (clk),
        .rst            (rst),
        .sampleIn       (txSampleIn),
        .sampleInValid  (txSampleInValid),
        .gain           (txGain),
        .sampleOut      (txSampleOut),
        .sampleOutValid (txSampleOutValid)
    );

endmodule

/* File: testbench/tcb_coeff_bank_monitor.sv */
`timescale 1ns/1ns
`include "tcb_params.svh"

module tcb_coeff_bank_monitor #(
    parameter int UPDATE_CYCLES = 16
) (
    // clock and reset
    input wire logic                          clk,
    input wire logic                          rst,
    // direct port registers
    input wire logic                          dataPortWrite,
    input wire tcb_pkg::tcb_word_type         dataPortIn,
    input wire logic                          addrPortWrite,
    input wire tcb_pkg::tcb_addr_type         addrPortIn,
    input wire tcb_pkg::tcb_word_type         indirectDataPort,
    input wire tcb_pkg::tcb_addr_type         indirectAddressPort,
    input wire logic                          indirectPendingFlag,
    input wire logic                          transferDone,
    // sample paths
    input wire logic                          rxSampleInValid,
    input wire logic                          rxSampleOutValid,
    input wire logic                          txSampleInValid,
    input wire logic signed [`TCB_WORD_W-1:0] txSampleOut
);
    default clocking monClk @(posedge clk); endclocking
    default disable iff (rst);

    AST_PEND_SET: assert property (addrPortWrite && !indirectPendingFlag |=> indirectPendingFlag)
        else $error("pending flag did not rise after address write");
    AST_PEND_BOUND: assert property ($rose(indirectPendingFlag) |->
        ##[1:UPDATE_CYCLES] !indirectPendingFlag)
        else $error("transfer not serviced within one update period");
    AST_FALL_DONE: assert property ($fell(indirectPendingFlag) |-> transferDone)
        else $error("pending cleared without completion pulse");
    AST_DONE_ONE: assert property (transferDone |-> $fell(indirectPendingFlag) ##1 !transferDone)
        else $error("completion pulse malformed");
    AST_REFUSE: assert property (indirectPendingFlag && (dataPortWrite || addrPortWrite) |=>
        $stable(indirectAddressPort) && (transferDone || $stable(indirectDataPort)))
        else $error("host write accepted while pending");
    AST_DATA_LOAD: assert property (dataPortWrite && !indirectPendingFlag |=>
        indirectDataPort == $past(dataPortIn))
        else $error("data register not loaded");
    AST_ADDR_LOAD: assert property (addrPortWrite && !indirectPendingFlag |=>
        indirectAddressPort == $past(addrPortIn))
        else $error("address register not loaded");
    AST_RX_VALID: assert property (1'b1 |=> rxSampleOutValid == $past(rxSampleInValid))
        else $error("receive valid not one cycle after input");
    AST_TX_HOLD: assert property (!txSampleInValid |=> $stable(txSampleOut))
        else $error("transmit output moved without valid input");
endmodule

bind tcb_coeff_bank tcb_coeff_bank_monitor #(.UPDATE_CYCLES(UPDATE_CYCLES)) uMon (
    .clk(clk), .rst(rst), .dataPortWrite(dataPortWrite), .dataPortIn(dataPortIn),
    .addrPortWrite(addrPortWrite), .addrPortIn(addrPortIn), .indirectDataPort(indirectDataPort),
    .indirectAddressPort(indirectAddressPort), .indirectPendingFlag(indirectPendingFlag),
    .transferDone(transferDone), .rxSampleInValid(rxSampleInValid),
    .rxSampleOutValid(rxSampleOutValid), .txSampleInValid(txSampleInValid),
    .txSampleOut(txSampleOut));

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`include "tcb_params.svh"

module tb_top;
    typedef struct packed {logic rd; logic [7:0] a; logic [15:0] v;} tcb_exp_type;
    typedef struct packed {logic [15:0] rx; logic [15:0] tx;} tcb_smp_type;
    logic               clk, rst, dataPortWrite, addrPortWrite, rxSampleInValid, txSampleInValid;
    logic        [15:0] dataPortIn, indirectDataPort, rnd, smp;
    logic        [7:0]  addrPortIn, indirectAddressPort;
    logic               indirectPendingFlag, transferDone, rxSampleOutValid, txSampleOutValid;
    logic signed [15:0] rxSampleIn, txSampleIn, rxSampleOut, txSampleOut;
    logic        [15:0] word [10];
    logic        [15:0] mem [68];
    logic        [15:0] gRx [3] = '{16'h0400, 16'h07FF, 16'h0000};
    logic        [15:0] gTx [3] = '{16'h0C00, 16'h0000, 16'h0400};
    tcb_exp_type        expQ [$];
    tcb_smp_type        smpQ [$];
    tcb_exp_type        e;
    tcb_smp_type        s;
    int                 failures, compares;

    tcb_coeff_bank #(.UPDATE_CYCLES(16)) uut (
        .clk(clk), .rst(rst), .dataPortWrite(dataPortWrite), .dataPortIn(dataPortIn),
        .addrPortWrite(addrPortWrite), .addrPortIn(addrPortIn), .indirectDataPort(indirectDataPort),
        .indirectAddressPort(indirectAddressPort), .indirectPendingFlag(indirectPendingFlag),
        .transferDone(transferDone), .tone1FrequencyCoeff(word[0]), .tone1Amplitude(word[1]),
        .tone1InitialPhase(word[2]), .tone2FrequencyCoeff(word[3]), .tone2Amplitude(word[4]),
        .tone2InitialPhase(word[5]), .ringDcOffset(word[6]), .ringFrequencyCoeff(word[7]),
        .ringAmplitude(word[8]), .ringInitialPhase(word[9]), .loopClosureUpperThreshold(),
        .ringTripThreshold(), .commonModeLowThreshold(), .commonModeHighThreshold(),
        .powerAlarmThresholdPair1(), .powerAlarmThresholdPair2(), .powerAlarmThresholdPair3(),
        .loopClosureFilterCoeff(), .ringTripFilterCoeff(), .thermalPolePair1(),
        .thermalPolePair2(), .thermalPolePair3(), .ringingCommonModeBias(),
        .converterOverheadVoltage(), .loopClosureLowerThreshold(), .rxSampleIn(rxSampleIn),
        .rxSampleInValid(rxSampleInValid), .rxSampleOut(rxSampleOut),
        .rxSampleOutValid(rxSampleOutValid), .txSampleIn(txSampleIn),
        .txSampleInValid(txSampleInValid), .txSampleOut(txSampleOut),
        .txSampleOutValid(txSampleOutValid));

    // ==========================================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [15:0] scale(input logic [15:0] d, input logic [11:0] g);
        logic signed [31:0] p;
        p = ($signed(d) * $signed(g)) >>> 10;
        if (p > 32767) return 16'h7FFF;
        if (p < -32768) return 16'h8000;
        return p[15:0];
    endfunction

    function automatic bit mapped(input int a);
        return a <= 9 || (a >= 13 && a <= 27) || a == 64 || a == 66;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task waitIdle;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (indirectPendingFlag !== 1'b0 && n < 200);
        if (n >= 200) begin
            failures++;
            $display("unexpected wait: transfer never completed");
            stop_test();
        end
    endtask

    task xfer(input logic rd, input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        if (!rd) begin
            dataPortWrite <= 1'b1;
            dataPortIn <= v;
            @(posedge clk);
            dataPortWrite <= 1'b0;
        end
        addrPortWrite <= 1'b1;
        addrPortIn <= a;
        expQ.push_back({rd, a, v});
        @(posedge clk);
        addrPortWrite <= 1'b0;
        waitIdle();
    endtask

    // ==========================================================================
    // result watcher
    always @(posedge clk) begin
        #1;
        if (transferDone === 1'b1) begin
            e = expQ.pop_front();
            if (e.rd) check("read data", indirectDataPort, e.v);
            else if (e.a < 10) check("generator word", word[e.a], e.v);
        end
        if (rxSampleOutValid === 1'b1) begin
            s = smpQ.pop_front();
            check("receive sample", rxSampleOut, s.rx);
            check("transmit sample", txSampleOut, s.tx);
            check("transmit valid", {15'h0000, txSampleOutValid}, 16'h0001);
        end
    end

    // ==========================================================================
    // stimulus
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        {rst, dataPortWrite, addrPortWrite, rxSampleInValid, txSampleInValid} = 5'h10;
        {dataPortIn, addrPortIn, rxSampleIn, txSampleIn} = '0;
        rnd = 16'h0014;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 68; i++) begin
            rnd = lfsr(rnd);
            mem[i] = mapped(i) ? rnd : 16'h0000;
            xfer(1'b0, 8'(i), rnd);
        end
        $display("test write sweep done");
        // read in flight, then a data and address write that must be ignored;
        // the strobe stays up so the refused pair lands while the read still waits
        @(posedge clk);
        addrPortWrite <= 1'b1;
        addrPortIn <= 8'h01;
        expQ.push_back({1'b1, 8'h01, mem[1]});
        @(posedge clk);
        {dataPortWrite, dataPortIn, addrPortIn} <= {1'b1, 16'hBEEF, 8'h05};
        @(posedge clk);
        {dataPortWrite, addrPortWrite} <= 2'h0;
        waitIdle();
        check("address register", {8'h00, indirectAddressPort}, 16'h0001);
        $display("test refusal done");
        for (int i = 0; i < 68; i++) xfer(1'b1, 8'(i), mem[i]);
        $display("test read sweep done");
        for (int k = 0; k < 3; k++) begin
            xfer(1'b0, 8'h0D, gRx[k]);
            xfer(1'b0, 8'h0E, gTx[k]);
            for (int j = 0; j < 6; j++) begin
                @(posedge clk);
                rnd = lfsr(rnd);
                smp = (j == 0) ? 16'h8000 : rnd;
                {rxSampleIn, txSampleIn, rxSampleInValid, txSampleInValid} <= {smp, ~smp, 2'h3};
                smpQ.push_back({scale(smp, gRx[k][11:0]), scale(~smp, gTx[k][11:0])});
            end
            @(posedge clk);
            {rxSampleInValid, txSampleInValid} <= 2'h0;
            repeat (2) @(posedge clk);
        end
        $display("test gain done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("data after reset", indirectDataPort, 16'h0000);
        check("pending after reset", {15'h0000, indirectPendingFlag}, 16'h0000);
        xfer(1'b0, 8'h02, 16'h1234);
        xfer(1'b1, 8'h02, 16'h1234);
        $display("test reset done");
        check("open notes", 16'(expQ.size() + smpQ.size()), 16'h0000);
        stop_test();
    end
endmodule
